/* mvx_lane.sv */
// shared constants for the multi-vector min/max and widening mac datapath,
// plus the per-element-size signed min/max lane array.
// assumes a fixed vector length; register files live outside the block.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// package
package mvx_pkg;
  localparam int VL_BITS      = 128;
  localparam int ZA_VECS      = VL_BITS / 8;
  localparam int ZA_IDX_W     = $clog2(ZA_VECS);
  localparam int SEG_BITS     = 128;
  localparam int ACC_EW       = 32;
  localparam int SRC_EW       = 16;
  localparam int ELTS_PER_SEG = SEG_BITS / ACC_EW;
  localparam int ACC_ELTS     = VL_BITS / ACC_EW;
  localparam int NUM_ESZ      = 4;
  localparam int BASE_EW      = 8;
  localparam int GRP_MAX      = 4;

  localparam logic [1:0] ESZ_B = 2'h0;
  localparam logic [1:0] ESZ_H = 2'h1;
  localparam logic [1:0] ESZ_S = 2'h2;
  localparam logic [1:0] ESZ_D = 2'h3;

  localparam logic [2:0] SEL_PREFIX = 3'h2;

  typedef enum logic [2:0] {
    OP_MIN_VEC,
    OP_MAX_VEC,
    OP_MIN_MULTI,
    OP_MAX_MULTI,
    OP_MAC_IDX
  } mvx_op_t;

  typedef enum logic [1:0] {
    GRP_ONE,
    GRP_TWO,
    GRP_FOUR
  } mvx_grp_t;
endpackage : mvx_pkg

// ============================================================
// signed min/max over every EW-wide lane of a vector
module mvx_minmax #(
  parameter int EW = 8
) (
  input  wire logic [mvx_pkg::VL_BITS-1:0] a,
  input  wire logic [mvx_pkg::VL_BITS-1:0] b,
  input  wire logic                        take_max,
  output logic      [mvx_pkg::VL_BITS-1:0] y
);
  for (genvar k = 0; k < mvx_pkg::VL_BITS / EW; k++) begin : g_lane
    logic signed [EW-1:0] ea;
    logic signed [EW-1:0] eb;
    assign ea = a[k*EW +: EW];
    assign eb = b[k*EW +: EW];
    // ties keep the first operand either way
    assign y[k*EW +: EW] = ((ea < eb) ^ take_max) || (ea == eb) ? ea : eb;
  end
endmodule : mvx_minmax

`default_nettype wire

/* mvx_datapath.sv */
// multi-vector signed min/max and indexed widening multiply-accumulate.
// assumes zero-wait register files: read data is valid in the same cycle
// as the registered read enable and address.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - size field 00/01/10/11 means 8/16/32/64
// - destructive group base is field times 2/4
// - group registers are consecutive, last is base+1 (pair) or base+3 (quad)
// - second group scaled alike, second is base+1
// - shared second vector limited to Z0-Z15
// - min-by-vector keeps signed smaller per element
// - multi min pairs register r, all elements
// - multi max pairs registers, keeps larger
// - all results buffered before any write
// - signed 16-bit products added into 32-bit array
// - three-bit index, same slot per 128-bit segment
// - index is high bit above low bits
// - select register is 010 then select field
// - offset is twice three- or two-bit field
// - mac first group aligned by appended zeros
// - stride is (vector bits / 8) / group count
// - base is select plus offset mod stride, even
// - segment holds 128 / 32 accumulator elements
// - mac undefined without second matrix version
// - even halfwords low vector, odd high vector
// - wrap-around add; base advances by stride
module mvx_datapath (
  input  wire logic                          core_clk,
  input  wire logic                          reset_n,
  input  wire logic                          issue_valid,
  input  wire mvx_pkg::mvx_op_t              issue_op,
  input  wire mvx_pkg::mvx_grp_t             issue_grp,
  input  wire logic [1:0]                    size_field,
  input  wire logic [3:0]                    dest_group_field,
  input  wire logic [4:0]                    first_source_field,
  input  wire logic [3:0]                    second_source_field,
  input  wire logic [1:0]                    select_reg_field,
  input  wire logic [2:0]                    three_bit_offset_field,
  input  wire logic [1:0]                    two_bit_offset_field,
  input  wire logic                          index_high_bit,
  input  wire logic [1:0]                    index_low_bits,
  input  wire logic                          streaming_enabled,
  input  wire logic                          za_enabled,
  input  wire logic                          matrix_v2_present,
  output logic                               busy_q,
  output logic                               done_q,
  output logic                               undef_q,
  output logic                               trap_disabled_q,
  output logic                               gpr_rd_en_q,
  output logic [4:0]                         gpr_rd_addr_q,
  input  wire logic [31:0]                   gpr_rd_data,
  output logic                               zrd_en_q,
  output logic [4:0]                         zrd_a_addr_q,
  output logic [4:0]                         zrd_b_addr_q,
  input  wire logic [mvx_pkg::VL_BITS-1:0]   zrd_a_data,
  input  wire logic [mvx_pkg::VL_BITS-1:0]   zrd_b_data,
  output logic                               za_rd_en_q,
  output logic [mvx_pkg::ZA_IDX_W-1:0]       za_rd_addr_q,
  input  wire logic [mvx_pkg::VL_BITS-1:0]   za_rd_lo_data,
  input  wire logic [mvx_pkg::VL_BITS-1:0]   za_rd_hi_data,
  output logic                               z_wr_en_q,
  output logic [4:0]                         z_wr_addr_q,
  output logic [mvx_pkg::VL_BITS-1:0]        z_wr_data_q,
  output logic                               za_wr_en_q,
  output logic [mvx_pkg::ZA_IDX_W-1:0]       za_wr_addr_q,
  output logic [mvx_pkg::VL_BITS-1:0]        za_wr_lo_q,
  output logic [mvx_pkg::VL_BITS-1:0]        za_wr_hi_q
);
  localparam int VL = mvx_pkg::VL_BITS;
  localparam int IW = mvx_pkg::ZA_IDX_W;
  localparam int AW = mvx_pkg::ZA_IDX_W + 3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PREP,
    ST_READ,
    ST_WRITE
  } mvx_state_t;

  mvx_state_t       state_q;
  mvx_state_t       state_d;
  logic [1:0]       cnt_q;
  logic [1:0]       cnt_d;
  logic             last_r;
  mvx_pkg::mvx_op_t op_q;
  mvx_pkg::mvx_grp_t grp_q;
  logic [2:0]       nreg_q;
  logic [1:0]       esz_q;
  logic [4:0]       a_base_q;
  logic [4:0]       b_base_q;
  logic             b_fixed_q;
  logic             is_mac_q;
  logic [3:0]       offset_q;
  logic [2:0]       idx_q;
  logic [IW-1:0]    vec_base_q;
  logic [VL-1:0]    res_lo_q [mvx_pkg::GRP_MAX];
  logic [VL-1:0]    res_hi_q [mvx_pkg::GRP_MAX];

  // ============================================================
  // issue decode
  logic             is_mac;
  logic             undef_dec;
  logic             trap_dec;
  logic             accept;
  logic [2:0]       nreg_dec;
  logic [4:0]       a_base_dec;
  logic [4:0]       b_base_dec;
  logic [3:0]       offset_dec;
  logic             grp_bad;

  always_comb begin
    is_mac  = (issue_op == mvx_pkg::OP_MAC_IDX);
    grp_bad = (issue_grp > mvx_pkg::GRP_FOUR) ||
              (!is_mac && issue_grp == mvx_pkg::GRP_ONE);
    undef_dec = (issue_op > mvx_pkg::OP_MAC_IDX) || grp_bad ||
                (is_mac && !matrix_v2_present);
    trap_dec = !streaming_enabled || (is_mac && !za_enabled);
    accept   = issue_valid && (state_q == ST_IDLE) && !undef_dec && !trap_dec;
    nreg_dec = (issue_grp == mvx_pkg::GRP_FOUR) ? 3'h4 :
               (issue_grp == mvx_pkg::GRP_TWO)  ? 3'h2 : 3'h1;
    if (is_mac) begin
      a_base_dec = (issue_grp == mvx_pkg::GRP_FOUR) ?
                   {first_source_field[2:0], 2'h0} :
                   (issue_grp == mvx_pkg::GRP_TWO) ?
                   {first_source_field[3:0], 1'h0} : first_source_field;
      b_base_dec = {1'h0, second_source_field};
    end else begin
      a_base_dec = (issue_grp == mvx_pkg::GRP_FOUR) ?
                   {dest_group_field[2:0], 2'h0} :
                   {dest_group_field, 1'h0};
      if (issue_op inside {mvx_pkg::OP_MIN_VEC, mvx_pkg::OP_MAX_VEC}) begin
        b_base_dec = {1'h0, second_source_field};
      end else begin
        b_base_dec = (issue_grp == mvx_pkg::GRP_FOUR) ?
                     {second_source_field[2:0], 2'h0} :
                     {second_source_field, 1'h0};
      end
    end
    offset_dec = (issue_grp == mvx_pkg::GRP_ONE) ?
                 {three_bit_offset_field, 1'h0} :
                 {1'h0, two_bit_offset_field, 1'h0};
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      op_q      <= mvx_pkg::OP_MIN_VEC;
      grp_q     <= mvx_pkg::GRP_TWO;
      nreg_q    <= 3'h2;
      esz_q     <= mvx_pkg::ESZ_B;
      a_base_q  <= 5'h0;
      b_base_q  <= 5'h0;
      b_fixed_q <= 1'b0;
      is_mac_q  <= 1'b0;
      offset_q  <= 4'h0;
      idx_q     <= 3'h0;
    end else if (accept) begin
      op_q      <= issue_op;
      grp_q     <= issue_grp;
      nreg_q    <= nreg_dec;
      esz_q     <= size_field;
      a_base_q  <= a_base_dec;
      b_base_q  <= b_base_dec;
      b_fixed_q <= !(issue_op inside {mvx_pkg::OP_MIN_MULTI,
                                      mvx_pkg::OP_MAX_MULTI});
      is_mac_q  <= is_mac;
      offset_q  <= offset_dec;
      idx_q     <= {index_high_bit, index_low_bits};
    end
  end

  // ============================================================
  // sequencing
  always_comb begin
    last_r  = (cnt_q == 2'(nreg_q - 3'h1));
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      ST_IDLE: if (accept) begin
        state_d = ST_PREP;
        cnt_d   = 2'h0;
      end
      ST_PREP: state_d = ST_READ;
      ST_READ: begin
        state_d = last_r ? ST_WRITE : ST_READ;
        cnt_d   = last_r ? 2'h0 : 2'(cnt_q + 2'h1);
      end
      ST_WRITE: begin
        state_d = last_r ? ST_IDLE : ST_WRITE;
        cnt_d   = last_r ? 2'h0 : 2'(cnt_q + 2'h1);
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      cnt_q   <= 2'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // ============================================================
  // array vector addressing
  logic [IW:0]   stride_c;
  logic [31:0]   vsum;
  logic [IW-1:0] vmod;
  logic [IW-1:0] vec0;

  always_comb begin
    unique case (grp_q)
      mvx_pkg::GRP_ONE:  stride_c = (IW+1)'(mvx_pkg::ZA_VECS);
      mvx_pkg::GRP_TWO:  stride_c = (IW+1)'(mvx_pkg::ZA_VECS / 2);
      mvx_pkg::GRP_FOUR: stride_c = (IW+1)'(mvx_pkg::ZA_VECS / 4);
      default:           stride_c = (IW+1)'(mvx_pkg::ZA_VECS);
    endcase
    vsum = gpr_rd_data + {28'h0, offset_q};
    vmod = vsum[IW-1:0] & IW'(stride_c - (IW+1)'(1));
    vec0 = {vmod[IW-1:1], 1'b0};
  end

  function automatic logic [IW-1:0] za_addr(input logic [IW-1:0] base,
                                            input logic [1:0] r);
    logic [AW-1:0] t;
    t = AW'(base) + AW'(stride_c) * AW'(r);
    return t[IW-1:0];
  endfunction : za_addr

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      vec_base_q <= '0;
    end else if (state_q == ST_PREP) begin
      vec_base_q <= is_mac_q ? vec0 : '0;
    end
  end

  // ============================================================
  // read ports
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      gpr_rd_en_q   <= 1'b0;
      gpr_rd_addr_q <= 5'h0;
      zrd_en_q      <= 1'b0;
      zrd_a_addr_q  <= 5'h0;
      zrd_b_addr_q  <= 5'h0;
      za_rd_en_q    <= 1'b0;
      za_rd_addr_q  <= '0;
    end else begin
      gpr_rd_en_q <= accept && is_mac;
      if (accept) begin
        gpr_rd_addr_q <= {mvx_pkg::SEL_PREFIX, select_reg_field};
      end
      zrd_en_q   <= (state_d == ST_READ);
      za_rd_en_q <= (state_d == ST_READ) && is_mac_q;
      if (state_d == ST_READ) begin
        zrd_a_addr_q <= 5'(a_base_q + 5'(cnt_d));
        zrd_b_addr_q <= b_fixed_q ? b_base_q :
                        5'(b_base_q + 5'(cnt_d));
        za_rd_addr_q <= (state_q == ST_PREP) ? vec0 :
                        za_addr(vec_base_q, cnt_d);
      end
    end
  end

  // ============================================================
  // element arithmetic
  logic [VL-1:0] mm_y [mvx_pkg::NUM_ESZ];
  logic [VL-1:0] mm_res;
  logic          take_max;

  assign take_max = (op_q inside {mvx_pkg::OP_MAX_VEC,
                                  mvx_pkg::OP_MAX_MULTI});

  for (genvar k = 0; k < mvx_pkg::NUM_ESZ; k++) begin : g_esz
    mvx_minmax #(
      .EW (mvx_pkg::BASE_EW << k)
    ) u_mm (
      .a        (zrd_a_data),
      .b        (zrd_b_data),
      .take_max (take_max),
      .y        (mm_y[k])
    );
  end

  always_comb begin
    unique case (esz_q)
      mvx_pkg::ESZ_B: mm_res = mm_y[0];
      mvx_pkg::ESZ_H: mm_res = mm_y[1];
      mvx_pkg::ESZ_S: mm_res = mm_y[2];
      mvx_pkg::ESZ_D: mm_res = mm_y[3];
    endcase
  end

  logic [VL-1:0] mac_lo;
  logic [VL-1:0] mac_hi;

  always_comb begin
    int                        seg;
    int                        s;
    logic signed [mvx_pkg::SRC_EW-1:0] m2;
    logic signed [mvx_pkg::SRC_EW-1:0] m1e;
    logic signed [mvx_pkg::SRC_EW-1:0] m1o;
    seg    = 0;
    s      = 0;
    m2     = '0;
    m1e    = '0;
    m1o    = '0;
    mac_lo = '0;
    mac_hi = '0;
    for (int e = 0; e < mvx_pkg::ACC_ELTS; e++) begin
      seg = e - (e % mvx_pkg::ELTS_PER_SEG);
      s   = 2 * seg + int'(idx_q);
      m2  = zrd_b_data[s*mvx_pkg::SRC_EW +: mvx_pkg::SRC_EW];
      m1e = zrd_a_data[(2*e)*mvx_pkg::SRC_EW +: mvx_pkg::SRC_EW];
      m1o = zrd_a_data[(2*e+1)*mvx_pkg::SRC_EW +: mvx_pkg::SRC_EW];
      // full signed product fits the accumulator; the add wraps
      mac_lo[e*mvx_pkg::ACC_EW +: mvx_pkg::ACC_EW] =
        za_rd_lo_data[e*mvx_pkg::ACC_EW +: mvx_pkg::ACC_EW] +
        mvx_pkg::ACC_EW'(m1e) * mvx_pkg::ACC_EW'(m2);
      mac_hi[e*mvx_pkg::ACC_EW +: mvx_pkg::ACC_EW] =
        za_rd_hi_data[e*mvx_pkg::ACC_EW +: mvx_pkg::ACC_EW] +
        mvx_pkg::ACC_EW'(m1o) * mvx_pkg::ACC_EW'(m2);
    end
  end

  // results held until every register of the group is done
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int r = 0; r < mvx_pkg::GRP_MAX; r++) begin
        res_lo_q[r] <= '0;
        res_hi_q[r] <= '0;
      end
    end else if (state_q == ST_READ) begin
      res_lo_q[cnt_q] <= is_mac_q ? mac_lo : mm_res;
      res_hi_q[cnt_q] <= mac_hi;
    end
  end

  // ============================================================
  // write ports and status
  logic wr_fwd; // one-register group: no buffered copy exists yet
  assign wr_fwd = (state_q == ST_READ) && (cnt_q == 2'h0);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      z_wr_en_q    <= 1'b0;
      z_wr_addr_q  <= 5'h0;
      z_wr_data_q  <= '0;
      za_wr_en_q   <= 1'b0;
      za_wr_addr_q <= '0;
      za_wr_lo_q   <= '0;
      za_wr_hi_q   <= '0;
    end else begin
      z_wr_en_q  <= (state_d == ST_WRITE) && !is_mac_q;
      za_wr_en_q <= (state_d == ST_WRITE) && is_mac_q;
      if (state_d == ST_WRITE) begin
        z_wr_addr_q  <= 5'(a_base_q + 5'(cnt_d));
        z_wr_data_q  <= wr_fwd ? mm_res : res_lo_q[cnt_d];
        za_wr_addr_q <= za_addr(vec_base_q, cnt_d);
        za_wr_lo_q   <= wr_fwd ? mac_lo : res_lo_q[cnt_d];
        za_wr_hi_q   <= wr_fwd ? mac_hi : res_hi_q[cnt_d];
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q          <= 1'b0;
      done_q          <= 1'b0;
      undef_q         <= 1'b0;
      trap_disabled_q <= 1'b0;
    end else begin
      busy_q  <= (state_d != ST_IDLE);
      done_q  <= (state_q == ST_WRITE) && last_r;
      undef_q <= issue_valid && (state_q == ST_IDLE) && undef_dec;
      trap_disabled_q <= issue_valid && (state_q == ST_IDLE) &&
                         !undef_dec && trap_dec;
    end
  end

  // ============================================================
  // checks
  logic [15:0] chk_a_q;
  logic [15:0] chk_b_q;
  logic [1:0]  rd_cnt_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      chk_a_q  <= 16'h0;
      chk_b_q  <= 16'h0;
      rd_cnt_q <= 2'h0;
    end else begin
      chk_a_q  <= zrd_a_data[15:0];
      chk_b_q  <= zrd_b_data[15:0];
      rd_cnt_q <= cnt_q;
    end
  end

  undef_block_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    issue_valid && state_q == ST_IDLE && is_mac && !matrix_v2_present
    |=> undef_q && !busy_q && !trap_disabled_q)
    else $error("mac without second version not refused");
  trap_block_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    issue_valid && state_q == ST_IDLE && !undef_dec && !streaming_enabled
    |=> trap_disabled_q && !busy_q ##1 !zrd_en_q && !z_wr_en_q)
    else $error("disabled streaming mode did not trap");
  sel_reg_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    gpr_rd_en_q |-> gpr_rd_addr_q[4:2] == mvx_pkg::SEL_PREFIX)
    else $error("select register outside the four allowed");
  quad_base_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    accept && !is_mac && issue_grp == mvx_pkg::GRP_FOUR
    |=> ##1 zrd_en_q && zrd_a_addr_q[1:0] == 2'h0 &&
        zrd_a_addr_q[4:2] == $past(dest_group_field[2:0], 2))
    else $error("four-group base not field times four");
  consec_reg_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    z_wr_en_q && $past(z_wr_en_q)
    |-> z_wr_addr_q == 5'($past(z_wr_addr_q) + 5'h1))
    else $error("group registers not consecutive");
  single_src_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    zrd_en_q && b_fixed_q && $past(zrd_en_q)
    |-> zrd_b_addr_q == $past(zrd_b_addr_q) && !zrd_b_addr_q[4])
    else $error("shared second vector moved or out of range");
  temp_first_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(z_wr_en_q) || $rose(za_wr_en_q)
    |-> $past(zrd_en_q) && !zrd_en_q)
    else $error("write began before all reads finished");
  even_base_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    za_rd_en_q |-> !za_rd_addr_q[0])
    else $error("array base vector is odd");
  za_stride_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    za_rd_en_q && $past(za_rd_en_q)
    |-> za_rd_addr_q == IW'($past(za_rd_addr_q) + stride_c))
    else $error("array base did not advance by stride");
  min_half_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == ST_READ && op_q == mvx_pkg::OP_MIN_VEC &&
    esz_q == mvx_pkg::ESZ_H
    |=> $signed(res_lo_q[rd_cnt_q][15:0]) <= $signed(chk_a_q) &&
        $signed(res_lo_q[rd_cnt_q][15:0]) <= $signed(chk_b_q) &&
        (res_lo_q[rd_cnt_q][15:0] == chk_a_q ||
         res_lo_q[rd_cnt_q][15:0] == chk_b_q))
    else $error("halfword minimum wrong");

  mac_quad_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    za_wr_en_q && grp_q == mvx_pkg::GRP_FOUR ##3 done_q);
  minmax_pair_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    z_wr_en_q && op_q == mvx_pkg::OP_MAX_MULTI ##1 done_q);
  trap_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    trap_disabled_q);
  undef_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    undef_q);
endmodule : mvx_datapath

`default_nettype wire

/* mvx_regs_model.sv */
// stand-in for the vector, array and general register files.
// assumes same-cycle reads from the datapath's registered addresses.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// register file model
module mvx_regs_model (
  input  wire logic         core_clk,
  input  wire logic         gpr_rd_en_q,
  input  wire logic [4:0]   gpr_rd_addr_q,
  output logic      [31:0]  gpr_rd_data,
  input  wire logic         zrd_en_q,
  input  wire logic [4:0]   zrd_a_addr_q,
  input  wire logic [4:0]   zrd_b_addr_q,
  output logic      [127:0] zrd_a_data,
  output logic      [127:0] zrd_b_data,
  input  wire logic         za_rd_en_q,
  input  wire logic [3:0]   za_rd_addr_q,
  output logic      [127:0] za_rd_lo_data,
  output logic      [127:0] za_rd_hi_data,
  input  wire logic         z_wr_en_q,
  input  wire logic [4:0]   z_wr_addr_q,
  input  wire logic [127:0] z_wr_data_q,
  input  wire logic         za_wr_en_q,
  input  wire logic [3:0]   za_wr_addr_q,
  input  wire logic [127:0] za_wr_lo_q,
  input  wire logic [127:0] za_wr_hi_q
);
  logic [127:0] z   [32];
  logic [127:0] za  [16];
  logic [31:0]  gpr [32];

  // idle ports show inverted contents, so a read outside its enable shows
  assign gpr_rd_data   = gpr_rd_en_q ? gpr[gpr_rd_addr_q] : ~gpr[gpr_rd_addr_q];
  assign zrd_a_data    = zrd_en_q ? z[zrd_a_addr_q] : ~z[zrd_a_addr_q];
  assign zrd_b_data    = zrd_en_q ? z[zrd_b_addr_q] : ~z[zrd_b_addr_q];
  assign za_rd_lo_data = za_rd_en_q ? za[za_rd_addr_q] : ~za[za_rd_addr_q];
  assign za_rd_hi_data = za_rd_en_q ? za[za_rd_addr_q + 4'h1]
                                    : ~za[za_rd_addr_q + 4'h1];

  always @(posedge core_clk) begin
    if (z_wr_en_q) z[z_wr_addr_q] <= z_wr_data_q;
    if (za_wr_en_q) begin
      za[za_wr_addr_q]        <= za_wr_lo_q;
      za[za_wr_addr_q + 4'h1] <= za_wr_hi_q;
    end
  end
endmodule : mvx_regs_model
`default_nettype wire

/* multivector_minmax_widening_mac_bench.sv */
// self-checking bench for mvx_datapath with a register file model.
// assumes mvx_pkg and the model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module multivector_minmax_widening_mac_bench;
  typedef struct {
    mvx_pkg::mvx_op_t op; mvx_pkg::mvx_grp_t grp;
    logic [1:0] sz; logic [3:0] dst; logic [3:0] src;
  } mvx_row_t;
  logic core_clk, reset_n, issue_valid, index_high_bit;
  logic streaming_enabled, za_enabled, matrix_v2_present;
  mvx_pkg::mvx_op_t  issue_op;
  mvx_pkg::mvx_grp_t issue_grp;
  logic [1:0] size_field, select_reg_field, two_bit_offset_field, index_low_bits;
  logic [3:0] dest_group_field, second_source_field, za_rd_addr_q, za_wr_addr_q;
  logic [4:0] first_source_field, gpr_rd_addr_q, zrd_a_addr_q, zrd_b_addr_q;
  logic [4:0] z_wr_addr_q;
  logic [2:0] three_bit_offset_field;
  logic busy_q, done_q, undef_q, trap_disabled_q, gpr_rd_en_q, zrd_en_q;
  logic za_rd_en_q, z_wr_en_q, za_wr_en_q;
  logic [31:0] gpr_rd_data;
  logic [127:0] zrd_a_data, zrd_b_data, za_rd_lo_data, za_rd_hi_data;
  logic [127:0] z_wr_data_q, za_wr_lo_q, za_wr_hi_q, ex, snap [32], zsnap [16];
  logic signed [31:0] p;
  int fails, samples_checked, n, nr, d, s, v;
  mvx_row_t rows [5] = '{
    '{mvx_pkg::OP_MIN_VEC, mvx_pkg::GRP_TWO, 2'h0, 4'h7, 4'hf},
    '{mvx_pkg::OP_MIN_VEC, mvx_pkg::GRP_FOUR, 2'h1, 4'h1, 4'h5},
    '{mvx_pkg::OP_MIN_MULTI, mvx_pkg::GRP_TWO, 2'h2, 4'hf, 4'h3},
    '{mvx_pkg::OP_MAX_MULTI, mvx_pkg::GRP_FOUR, 2'h3, 4'h7, 4'h0},
    '{mvx_pkg::OP_MAX_VEC, mvx_pkg::GRP_TWO, 2'h2, 4'h0, 4'h1}};

  mvx_datapath uut (.core_clk, .reset_n, .issue_valid, .issue_op, .issue_grp,
    .size_field, .dest_group_field, .first_source_field, .second_source_field,
    .select_reg_field, .three_bit_offset_field, .two_bit_offset_field,
    .index_high_bit, .index_low_bits, .streaming_enabled, .za_enabled,
    .matrix_v2_present, .busy_q, .done_q, .undef_q, .trap_disabled_q,
    .gpr_rd_en_q, .gpr_rd_addr_q, .gpr_rd_data, .zrd_en_q, .zrd_a_addr_q,
    .zrd_b_addr_q, .zrd_a_data, .zrd_b_data, .za_rd_en_q, .za_rd_addr_q,
    .za_rd_lo_data, .za_rd_hi_data, .z_wr_en_q, .z_wr_addr_q, .z_wr_data_q,
    .za_wr_en_q, .za_wr_addr_q, .za_wr_lo_q, .za_wr_hi_q);
  mvx_regs_model model (.core_clk, .gpr_rd_en_q, .gpr_rd_addr_q, .gpr_rd_data,
    .zrd_en_q, .zrd_a_addr_q, .zrd_b_addr_q, .zrd_a_data, .zrd_b_data,
    .za_rd_en_q, .za_rd_addr_q, .za_rd_lo_data, .za_rd_hi_data, .z_wr_en_q,
    .z_wr_addr_q, .z_wr_data_q, .za_wr_en_q, .za_wr_addr_q, .za_wr_lo_q,
    .za_wr_hi_q);

  // ============================================================
  // helpers
  task automatic chk(input logic c, input string m);
    samples_checked++;
    if (c !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  // waits for any completion pulse, counting falling edges after the take
  task automatic run(input mvx_pkg::mvx_op_t o, input mvx_pkg::mvx_grp_t g);
    issue_op = o;
    issue_grp = g;
    issue_valid = 1'b1;
    @(negedge core_clk);
    issue_valid = 1'b0;
    n = 0;
    while (!(done_q || undef_q || trap_disabled_q) && n < 40) begin
      @(negedge core_clk);
      n++;
    end
  endtask : run

  // ties keep the first operand; sign bit flipped for signed order
  function automatic logic [127:0] mm(input logic [127:0] a, b, input int ew,
                                      input bit mx);
    logic [63:0] x, y, sb;
    mm = a;
    sb = 64'h1 << (ew - 1);
    for (int e = 0; e < 128 / ew; e++) begin
      x = 64'(a >> (e * ew)) & ((sb << 1) - 64'h1);
      y = 64'(b >> (e * ew)) & ((sb << 1) - 64'h1);
      if (mx ? ((y ^ sb) > (x ^ sb)) : ((y ^ sb) < (x ^ sb)))
        for (int k = 0; k < ew; k++) mm[e * ew + k] = y[k];
    end
  endfunction : mm

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // whole run is under a hundred cycles; the 2000-cycle limit leaves ample margin
  initial begin
    #80000;
    fails++;
    report_and_stop();
  end

  // ============================================================
  // tests
  initial begin
    {reset_n, issue_valid, index_high_bit, index_low_bits} = '0;
    {streaming_enabled, za_enabled, matrix_v2_present} = 3'h7;
    {size_field, select_reg_field} = '0;
    {two_bit_offset_field, dest_group_field, second_source_field} = '0;
    {first_source_field, three_bit_offset_field} = '0;
    for (int i = 0; i < 32; i++) begin
      model.gpr[i] = 32'hffff_fff0 + 32'(i);
      for (int k = 0; k < 16; k++) model.z[i][k * 8 +: 8] = 8'(i * 37 + k * 91 + 5);
    end
    for (int i = 0; i < 16; i++) model.za[i] = {4{32'(i * 12345 + 7)}};
    repeat (12) @(negedge core_clk);
    chk(busy_q === 1'b0 && done_q === 1'b0 && z_wr_en_q === 1'b0, "reset state");
    reset_n = 1'b1;
    @(negedge core_clk);
    foreach (rows[i]) begin
      nr = rows[i].grp == mvx_pkg::GRP_TWO ? 2 : 4;
      snap = model.z;
      size_field = rows[i].sz;
      dest_group_field = rows[i].dst;
      second_source_field = rows[i].src;
      run(rows[i].op, rows[i].grp);
      chk(done_q === 1'b1 && n >= 2 * nr + 1 && n <= 2 * nr + 3, "mm done");
      for (int r = 0; r < nr; r++) begin
        d = rows[i].dst * nr + r;
        s = rows[i].op inside {mvx_pkg::OP_MIN_VEC, mvx_pkg::OP_MAX_VEC}
            ? rows[i].src : rows[i].src * nr + r;
        ex = mm(snap[d], snap[s], 8 << rows[i].sz, rows[i].op inside
                {mvx_pkg::OP_MAX_VEC, mvx_pkg::OP_MAX_MULTI});
        chk(model.z[d] === ex, "minmax result");
      end
    end
    for (int g = 0; g < 3; g++) begin
      nr = 1 << g;
      snap = model.z;
      zsnap = model.za;
      select_reg_field = 2'(g + 1);
      three_bit_offset_field = 3'h5;
      two_bit_offset_field = 2'h3;
      {index_high_bit, index_low_bits} = 3'(g * 3 + 1);
      first_source_field = 5'h1d;
      second_source_field = 4'h9;
      run(mvx_pkg::OP_MAC_IDX, mvx_pkg::mvx_grp_t'(g));
      chk(done_q === 1'b1 && n >= 2 * nr + 1 && n <= 2 * nr + 3, "mac done");
      v = int'(({32'h0, model.gpr[g + 9]} + (g == 0 ? 10 : 6)) % (16 / nr));
      v = v - v % 2;
      d = g == 0 ? 29 : (g == 1 ? 26 : 20);
      for (int r = 0; r < nr; r++)
        for (int i = 0; i < 2; i++) begin
          ex = zsnap[v + r * (16 / nr) + i];
          for (int e = 0; e < 4; e++) begin
            p = $signed(snap[d + r][(2 * e + i) * 16 +: 16])
                * $signed(snap[9][(g * 3 + 1) * 16 +: 16]);
            ex[e * 32 +: 32] = ex[e * 32 +: 32] + p;
          end
          chk(model.za[v + r * (16 / nr) + i] === ex, "mac result");
        end
    end
    snap = model.z;
    streaming_enabled = 1'b0;
    run(mvx_pkg::OP_MIN_VEC, mvx_pkg::GRP_TWO);
    chk(trap_disabled_q === 1'b1 && undef_q === 1'b0 && n <= 2, "trap");
    @(negedge core_clk);
    chk(model.z[0] === snap[0] && busy_q === 1'b0, "trap wrote");
    matrix_v2_present = 1'b0;
    zsnap = model.za;
    run(mvx_pkg::OP_MAC_IDX, mvx_pkg::GRP_ONE);
    chk(undef_q === 1'b1 && trap_disabled_q === 1'b0, "undef");
    {streaming_enabled, za_enabled, matrix_v2_present} = 3'h5;
    run(mvx_pkg::OP_MAC_IDX, mvx_pkg::GRP_ONE);
    chk(trap_disabled_q === 1'b1 && undef_q === 1'b0, "za trap");
    @(negedge core_clk);
    foreach (zsnap[i]) chk(model.za[i] === zsnap[i], "array wrote");
    report_and_stop();
  end
endmodule : multivector_minmax_widening_mac_bench
`default_nettype wire
